// ==== pmp_core.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "pmp_params.svh"
// Functional notes
// - Current gain select bit picks front-end gain 10x when 0, 50x when 1.
// - Voltage and current each get programmable digital gain up to 4x.
// - One mode bit enables fourth-order roll-off compensation on both channels.
// - Separate mode bits enable DC blocking on voltage and current channels.
// - With DC blocking on one channel only, the other gets an all-pass.
// - Instantaneous samples come at clock divided by K then by 1024.
// - RMS and active power average over N samples from cycle count register.
// - Apparent power is RMS voltage times RMS current of same cycle.
// - Signed results are two's complement fractions; largest code is (2^23-1)/2^23.
// - Each sample sets sample-ready flag; unmasked flag drives interrupt pin.
// - Each cycle end sets cycle-done flag; unmasked flag drives interrupt pin.
// - A set flag stays set until host clears it.
// - Cycle count 1 updates all results except reactive average every sample; cycle-done follows sample-ready.
// - Cycle count below 2 inhibits some calculations.
// - Epsilon sets reference oscillator frequency and quadrature filter gain.
// - After reset pin1 active energy, pin3 reactive, pin2 energy sign.
// - Pin2 mode bit 0 makes pin2 show energy sign.
// - Pin2 mode bit 1 makes pin2 carry apparent energy pulses, no sign.
// - Pin3 mode 00 reactive, 01 supply monitor, 10 voltage sign, 11 apparent.
// - Pin1 low pulses track active power; pin2 high at fall means positive.
// - Pulse low time is pulse width register times one sample period.
module pmp_core
	import pmp_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        nrst_in,
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic [31:0] hwdata_in,
	input  wire logic        hready_in,
	output logic             hreadyout_out,
	output logic             hresp_out,
	output logic      [31:0] hrdata_out,
	input  wire logic [23:0] vsamp_in,
	input  wire logic [23:0] isamp_in,
	input  wire logic        supply_monitor_compare_in,
	output logic             current_pga_high_out,
	output logic             irq_n_out,
	output logic             active_pulse_out_n,
	output logic             sign_or_apparent_out,
	output logic             third_pulse_out_n
);
	////////////////////////////////////////////////////////////////////////////////
	// Arithmetic helpers
	function automatic logic signed [23:0] pmp_sat(input logic signed [59:0] x);
		if (x > 60'sh00000000007FFFFF)
			return 24'sh7FFFFF;
		else if (x < -60'sh0000000000800000)
			return 24'sh800000;
		else
			return x[23:0];
	endfunction : pmp_sat

	function automatic logic signed [23:0] pmp_fmul(input logic signed [23:0] a,
		input logic signed [23:0] b);
		return pmp_sat(60'(a * b) >>> 23);
	endfunction : pmp_fmul

	function automatic logic signed [23:0] pmp_gain(input logic signed [23:0] x,
		input logic [23:0] g);
		return pmp_sat(60'(x * $signed({1'b0, g})) >>> 22);
	endfunction : pmp_gain

	function automatic logic signed [23:0] pmp_rolloff(input logic signed [23:0] x,
		input logic signed [23:0] t0, input logic signed [23:0] t1,
		input logic signed [23:0] t2, input logic signed [23:0] t3);
		logic signed [27:0] d;
		d = (28'(x) <<< 2) - 28'(t0) - 28'(t1) - 28'(t2) - 28'(t3);
		return pmp_sat(60'(x) + 60'(d >>> 4));
	endfunction : pmp_rolloff

	function automatic logic signed [23:0] pmp_allpass(input logic signed [23:0] x,
		input logic signed [23:0] x1, input logic signed [23:0] y1);
		logic signed [25:0] e;
		e = 26'(x) - 26'(y1);
		return pmp_sat(60'(x1) - 60'(e) + 60'(e >>> 10));
	endfunction : pmp_allpass

	function automatic logic signed [25:0] pmp_escale(input logic signed [23:0] p,
		input logic [23:0] r);
		return 26'(60'(p * $signed({1'b0, r})) >>> 24);
	endfunction : pmp_escale

	function automatic logic [23:0] pmp_isqrt(input logic [47:0] x);
		logic [23:0] r;
		logic [23:0] t;
		r = 24'h000000;
		for (int b = 23; b >= 0; b--) begin
			t = r | (24'h000001 << b);
			if (48'(t * t) <= x)
				r = t;
		end
		return r;
	endfunction : pmp_isqrt

	////////////////////////////////////////////////////////////////////////////////
	// Register state
	logic [31:0]        cfg_q;
	logic [5:0]         mode_q;
	logic [23:0]        vgain_q, igain_q, cyc_q, eps_q, prate_q;
	logic [15:0]        pwidth_q;
	logic [1:0]         st_q, mask_q;
	logic signed [23:0] vinst_q, iinst_q, pinst_q, qinst_q, pact_q, qavg_q;
	logic [23:0]        vrms_q, irms_q, sapp_q, phase_q;
	logic               ap_q, wr_q, samp_done_q, publish_q;
	logic [7:0]         wa_q;
	logic [31:0]        rd_d;
	logic [1:0]         st_clr;

	// Address phase decode, zero wait states
	assign ap_q = hsel_in & htrans_in[1] & hready_in & (hsize_in == 3'h2);
	assign hreadyout_out = 1'b1;
	assign hresp_out = 1'b0;
	assign st_clr = (wr_q && wa_q == `PMP_OFS_STATUS) ? hwdata_in[1:0] : 2'h0;

	// Latch write address; capture read data in address phase
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			wr_q <= 1'b0;
			wa_q <= 8'h00;
			hrdata_out <= 32'h00000000;
		end else begin
			wr_q <= ap_q & hwrite_in;
			wa_q <= haddr_in[7:0];
			hrdata_out <= (ap_q & ~hwrite_in) ? rd_d : 32'h00000000;
		end
	end

	// Read mux, unmapped reads as zero
	always_comb begin
		rd_d = 32'h00000000;
		case (haddr_in[7:0])
			`PMP_OFS_CONFIG:  rd_d = cfg_q;
			`PMP_OFS_MODE:    rd_d = {26'h0, mode_q};
			`PMP_OFS_VGAIN:   rd_d = {8'h00, vgain_q};
			`PMP_OFS_IGAIN:   rd_d = {8'h00, igain_q};
			`PMP_OFS_CYCLES:  rd_d = {8'h00, cyc_q};
			`PMP_OFS_EPSILON: rd_d = {8'h00, eps_q};
			`PMP_OFS_PRATE:   rd_d = {8'h00, prate_q};
			`PMP_OFS_PWIDTH:  rd_d = {16'h0000, pwidth_q};
			`PMP_OFS_STATUS:  rd_d = {30'h0, st_q};
			`PMP_OFS_MASK:    rd_d = {30'h0, mask_q};
			`PMP_OFS_VINST:   rd_d = {{8{vinst_q[23]}}, vinst_q};
			`PMP_OFS_IINST:   rd_d = {{8{iinst_q[23]}}, iinst_q};
			`PMP_OFS_PINST:   rd_d = {{8{pinst_q[23]}}, pinst_q};
			`PMP_OFS_VRMS:    rd_d = {8'h00, vrms_q};
			`PMP_OFS_IRMS:    rd_d = {8'h00, irms_q};
			`PMP_OFS_PACT:    rd_d = {{8{pact_q[23]}}, pact_q};
			`PMP_OFS_SAPP:    rd_d = {8'h00, sapp_q};
			`PMP_OFS_QAVG:    rd_d = {{8{qavg_q[23]}}, qavg_q};
			`PMP_OFS_PHASE:   rd_d = {8'h00, phase_q};
			default:          rd_d = 32'h00000000;
		endcase
	end

	// Control register writes in data phase
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			cfg_q <= `PMP_RST_CONFIG;
			mode_q <= `PMP_RST_MODE;
			vgain_q <= `PMP_RST_GAIN;
			igain_q <= `PMP_RST_GAIN;
			cyc_q <= `PMP_RST_CYCLES;
			eps_q <= `PMP_RST_EPSILON;
			prate_q <= `PMP_RST_PRATE;
			pwidth_q <= `PMP_RST_PWIDTH;
			mask_q <= 2'h0;
		end else if (wr_q) begin
			case (wa_q)
				`PMP_OFS_CONFIG:  cfg_q <= {24'h0, hwdata_in[7:4], 3'h0, hwdata_in[0]};
				`PMP_OFS_MODE:    mode_q <= hwdata_in[5:0];
				`PMP_OFS_VGAIN:   vgain_q <= hwdata_in[23:0];
				`PMP_OFS_IGAIN:   igain_q <= hwdata_in[23:0];
				`PMP_OFS_CYCLES:  cyc_q <= hwdata_in[23:0];
				`PMP_OFS_EPSILON: eps_q <= hwdata_in[23:0];
				`PMP_OFS_PRATE:   prate_q <= hwdata_in[23:0];
				`PMP_OFS_PWIDTH:  pwidth_q <= hwdata_in[15:0];
				`PMP_OFS_MASK:    mask_q <= hwdata_in[1:0];
				default:          mask_q <= mask_q;
			endcase
		end
	end

	// Front-end gain range select to analog PGA
	assign current_pga_high_out = cfg_q[`PMP_CFG_PGA];

	////////////////////////////////////////////////////////////////////////////////
	// Word rate divider
	logic [3:0]  kdiv;
	logic [15:0] period_m1, presc_q;
	logic        tick;
	assign kdiv = (cfg_q[7:4] == 4'h0) ? 4'h1 : cfg_q[7:4];
	assign period_m1 = ({2'h0, kdiv, 10'h000}) - 16'h0001;
	assign tick = (presc_q >= period_m1);

	// Counts K times 1024 clocks per sample
	always_ff @(posedge clk_in) begin
		if (!nrst_in)
			presc_q <= 16'h0000;
		else
			presc_q <= tick ? 16'h0000 : presc_q + 16'h0001;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Channel filter chain
	logic signed [23:0] vtap_q [4];
	logic signed [23:0] itap_q [4];
	logic signed [23:0] vdc_q, idc_q, vx1_q, vy1_q, ix1_q, iy1_q;
	logic signed [23:0] gv, gi, rv, ri, av, ai, fv, fi;
	logic               vdc_en, idc_en;
	assign vdc_en = mode_q[`PMP_MODE_VDC];
	assign idc_en = mode_q[`PMP_MODE_IDC];
	assign gv = pmp_gain(vsamp_in, vgain_q);
	assign gi = pmp_gain(isamp_in, igain_q);
	assign rv = mode_q[`PMP_MODE_ROLLOFF] ?
		pmp_rolloff(gv, vtap_q[0], vtap_q[1], vtap_q[2], vtap_q[3]) : gv;
	assign ri = mode_q[`PMP_MODE_ROLLOFF] ?
		pmp_rolloff(gi, itap_q[0], itap_q[1], itap_q[2], itap_q[3]) : gi;
	assign av = pmp_allpass(rv, vx1_q, vy1_q);
	assign ai = pmp_allpass(ri, ix1_q, iy1_q);
	assign fv = vdc_en ? pmp_sat(60'(rv) - 60'(vdc_q)) : (idc_en ? av : rv);
	assign fi = idc_en ? pmp_sat(60'(ri) - 60'(idc_q)) : (vdc_en ? ai : ri);

	// Filter state and instantaneous results once per sample
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			for (int t = 0; t < 4; t++) begin
				vtap_q[t] <= 24'sh000000;
				itap_q[t] <= 24'sh000000;
			end
			{vdc_q, idc_q, vx1_q, vy1_q, ix1_q, iy1_q} <= 144'h0;
			{vinst_q, iinst_q, pinst_q} <= 72'h0;
			samp_done_q <= 1'b0;
		end else begin
			samp_done_q <= tick;
			if (tick) begin
				vtap_q <= '{gv, vtap_q[0], vtap_q[1], vtap_q[2]};
				itap_q <= '{gi, itap_q[0], itap_q[1], itap_q[2]};
				vdc_q <= pmp_sat(60'(vdc_q) + (60'(60'(rv) - 60'(vdc_q)) >>> 10));
				idc_q <= pmp_sat(60'(idc_q) + (60'(60'(ri) - 60'(idc_q)) >>> 10));
				vx1_q <= rv;
				vy1_q <= av;
				ix1_q <= ri;
				iy1_q <= ai;
				vinst_q <= fv;
				iinst_q <= fi;
				pinst_q <= pmp_fmul(fv, fi);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Quadrature voltage and reference phase
	logic signed [31:0] qacc_q;
	logic signed [59:0] qm, qw;
	logic signed [23:0] vquad;
	assign qm = 60'(qacc_q * $signed({1'b0, eps_q}));
	assign qw = (qm <<< 2) + (qm <<< 1) + (qm >>> 2);
	assign vquad = pmp_sat(qw >>> 24);
	assign qinst_q = pmp_fmul(vquad, iinst_q);

	// Leaky integrator, gain scaled by epsilon
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			qacc_q <= 32'sh00000000;
			phase_q <= 24'h000000;
		end else if (samp_done_q) begin
			qacc_q <= qacc_q + 32'(vinst_q) - (qacc_q >>> 10);
			phase_q <= phase_q + eps_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Computation cycle accumulation and results
	logic [23:0]        n_eff, cnt_q, vrms_d, irms_d;
	logic [47:0]        sv_q, si_q, sv_s, si_s, mv_q, mi_q;
	logic signed [47:0] sp_q, sq_q, sp_s, sq_s, mp_q, mq_q;
	logic               last;
	pmp_calc_state_type calc_q;
	assign n_eff = (cyc_q == 24'h000000) ? 24'h000001 : cyc_q;
	assign last = samp_done_q && (cnt_q >= n_eff - 24'h000001);
	assign vrms_d = pmp_isqrt({mv_q[24:0], 23'h000000});
	assign irms_d = pmp_isqrt({mi_q[24:0], 23'h000000});

	// Sums over N samples, then mean, root and product
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			{cnt_q, sv_q, si_q, sp_q, sq_q, sv_s, si_s, sp_s, sq_s} <= 408'h0;
			{mv_q, mi_q, mp_q, mq_q} <= 192'h0;
			{vrms_q, irms_q, sapp_q, pact_q, qavg_q} <= 120'h0;
			calc_q <= CALC_IDLE;
			publish_q <= 1'b0;
		end else begin
			publish_q <= 1'b0;
			if (samp_done_q) begin
				sv_q <= last ? 48'h0 : sv_q + (48'(vinst_q * vinst_q) >> 23);
				si_q <= last ? 48'h0 : si_q + (48'(iinst_q * iinst_q) >> 23);
				sp_q <= last ? 48'sh0 : sp_q + 48'(pinst_q);
				sq_q <= last ? 48'sh0 : sq_q + 48'(qinst_q);
				cnt_q <= last ? 24'h000000 : cnt_q + 24'h000001;
			end
			if (last) begin
				sv_s <= sv_q + (48'(vinst_q * vinst_q) >> 23);
				si_s <= si_q + (48'(iinst_q * iinst_q) >> 23);
				sp_s <= sp_q + 48'(pinst_q);
				sq_s <= sq_q + 48'(qinst_q);
			end
			case (calc_q)
				CALC_IDLE: if (last) calc_q <= CALC_MEAN;
				CALC_MEAN: begin
					mv_q <= sv_s / 48'(n_eff);
					mi_q <= si_s / 48'(n_eff);
					mp_q <= sp_s / $signed({24'h0, n_eff});
					mq_q <= sq_s / $signed({24'h0, n_eff});
					calc_q <= CALC_ROOT;
				end
				CALC_ROOT: begin
					vrms_q <= vrms_d;
					irms_q <= irms_d;
					sapp_q <= 24'(48'(vrms_d * irms_d) >> 23);
					pact_q <= pmp_sat(60'(mp_q));
					if (n_eff >= 24'h000002)
						qavg_q <= pmp_sat(60'(mq_q));
					publish_q <= 1'b1;
					calc_q <= CALC_IDLE;
				end
				default: calc_q <= CALC_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Status flags and interrupt
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			st_q <= 2'h0;
			irq_n_out <= 1'b1;
		end else begin
			st_q[`PMP_ST_SAMPLE] <= samp_done_q | (st_q[0] & ~st_clr[0]);
			st_q[`PMP_ST_CYCLE] <= publish_q | (st_q[1] & ~st_clr[1]);
			irq_n_out <= ~|(st_q & mask_q);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Energy to pulse conversion: active, reactive, apparent
	logic signed [25:0] eadd [3];
	logic signed [26:0] eacc_q [3];
	logic signed [26:0] enext [3];
	logic [15:0]        ecnt_q [3];
	logic [2:0]         fire, fneg, estart_q;
	logic [15:0]        pw_eff;
	logic               epos_q, mon_s1_q, mon_s2_q;
	assign pw_eff = (pwidth_q == 16'h0000) ? 16'h0001 : pwidth_q;
	assign eadd[0] = pmp_escale(pinst_q, prate_q);
	assign eadd[1] = pmp_escale(qinst_q, prate_q);
	assign eadd[2] = pmp_escale($signed({1'b0, sapp_q[22:0]}), prate_q);

	// Fire on threshold crossing, bounded accumulator
	always_comb begin
		for (int k = 0; k < 3; k++) begin
			enext[k] = eacc_q[k] + 27'(eadd[k]);
			fire[k] = 1'b0;
			fneg[k] = 1'b0;
			if (ecnt_q[k] == 16'h0000 && !estart_q[k]) begin
				if (enext[k] >= `PMP_ENERGY_THR) begin
					fire[k] = 1'b1;
					enext[k] = enext[k] - `PMP_ENERGY_THR;
				end else if (enext[k] <= -`PMP_ENERGY_THR) begin
					fire[k] = 1'b1;
					fneg[k] = 1'b1;
					enext[k] = enext[k] + `PMP_ENERGY_THR;
				end
			end
			if (enext[k] > (`PMP_ENERGY_THR <<< 1))
				enext[k] = `PMP_ENERGY_THR <<< 1;
			else if (enext[k] < -(`PMP_ENERGY_THR <<< 1))
				enext[k] = -(`PMP_ENERGY_THR <<< 1);
		end
	end

	// Sign leads the pulse edge; low time counted in samples
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			for (int k = 0; k < 3; k++) begin
				eacc_q[k] <= 27'sh0;
				ecnt_q[k] <= 16'h0000;
			end
			estart_q <= 3'h0;
			epos_q <= 1'b1;
		end else begin
			estart_q <= samp_done_q ? fire : 3'h0;
			if (samp_done_q && fire[0])
				epos_q <= ~fneg[0];
			else if (samp_done_q && fire[1])
				epos_q <= ~fneg[1];
			for (int k = 0; k < 3; k++) begin
				if (samp_done_q)
					eacc_q[k] <= enext[k];
				if (estart_q[k])
					ecnt_q[k] <= pw_eff;
				else if (samp_done_q && ecnt_q[k] != 16'h0000)
					ecnt_q[k] <= ecnt_q[k] - 16'h0001;
			end
		end
	end

	// Supply monitor pin synchroniser
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			mon_s1_q <= 1'b0;
			mon_s2_q <= 1'b0;
		end else begin
			mon_s1_q <= supply_monitor_compare_in;
			mon_s2_q <= mon_s1_q;
		end
	end

	// Pin output selection
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			active_pulse_out_n <= 1'b1;
			sign_or_apparent_out <= 1'b1;
			third_pulse_out_n <= 1'b1;
		end else begin
			active_pulse_out_n <= (ecnt_q[0] == 16'h0000);
			sign_or_apparent_out <= mode_q[`PMP_MODE_PIN2] ?
				(ecnt_q[2] == 16'h0000) : epos_q;
			case (mode_q[5:4])
				2'h0:    third_pulse_out_n <= (ecnt_q[1] == 16'h0000);
				2'h1:    third_pulse_out_n <= mon_s2_q;
				2'h2:    third_pulse_out_n <= ~vinst_q[23];
				default: third_pulse_out_n <= (ecnt_q[2] == 16'h0000);
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	logic [15:0] gap_q;
	logic        seen_q;
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			gap_q <= 16'h0000;
			seen_q <= 1'b0;
		end else begin
			gap_q <= tick ? 16'h0000 : gap_q + 16'h0001;
			seen_q <= (wr_q && wa_q == `PMP_OFS_CONFIG) ? 1'b0 : (seen_q | tick);
		end
	end

	irq_level_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(|(st_q & mask_q)) |=> !irq_n_out) else $error("interrupt not active");
	flag_sticky_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(st_q[1] && !st_clr[1]) |=> st_q[1]) else $error("cycle flag dropped");
	sample_flag_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		tick |=> ##1 st_q[0]) else $error("sample flag not set");
	cycle_flag_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		last |-> ##4 st_q[1]) else $error("cycle flag not set");
	apparent_prod_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		publish_q |-> sapp_q == 24'(48'(vrms_q * irms_q) >> 23)) else $error("bad product");
	word_rate_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(tick && seen_q && $stable(cfg_q)) |-> gap_q == period_m1) else $error("bad rate");
	pin2_sign_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		!mode_q[3] |=> sign_or_apparent_out == $past(epos_q)) else $error("pin2 not sign");
	pin3_vsign_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		mode_q[5:4] == 2'h2 |=> third_pulse_out_n == !$past(vinst_q[23])) else $error("pin3");
endmodule : pmp_core
`default_nettype wire

// ==== pmp_far_model.sv ====
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// External energy counter on the pulse pins
module pmp_far_model (
	input  wire logic        clk_in,
	input  wire logic        e1_n_in,
	input  wire logic        e2_in,
	output logic      [15:0] e1_falls_out,
	output logic      [15:0] e1_pos_out,
	output logic      [15:0] e2_falls_out
);
	logic        e1_q = 1'b1;
	logic        e2_q = 1'b1;
	logic [15:0] f1_q = 16'h0000;
	logic [15:0] fp_q = 16'h0000;
	logic [15:0] f2_q = 16'h0000;
	// Counters seen by the bench
	assign e1_falls_out = f1_q;
	assign e1_pos_out = fp_q;
	assign e2_falls_out = f2_q;
	// Count falls; sign pin high at a fall means positive energy
	always @(posedge clk_in) begin
		e1_q <= e1_n_in;
		e2_q <= e2_in;
		if (e1_q && !e1_n_in) begin
			f1_q <= f1_q + 16'h0001;
			if (e2_in) begin
				fp_q <= fp_q + 16'h0001;
			end
		end
		if (e2_q && !e2_in) begin
			f2_q <= f2_q + 16'h0001;
		end
	end
endmodule : pmp_far_model
`default_nettype wire

// ==== pmp_params.svh ====
`ifndef PMP_PARAMS_SVH
`define PMP_PARAMS_SVH
// Register byte offsets
`define PMP_OFS_CONFIG  8'h00
`define PMP_OFS_MODE    8'h04
`define PMP_OFS_VGAIN   8'h08
`define PMP_OFS_IGAIN   8'h0C
`define PMP_OFS_CYCLES  8'h10
`define PMP_OFS_EPSILON 8'h14
`define PMP_OFS_PRATE   8'h18
`define PMP_OFS_PWIDTH  8'h1C
`define PMP_OFS_STATUS  8'h20
`define PMP_OFS_MASK    8'h24
`define PMP_OFS_VINST   8'h28
`define PMP_OFS_IINST   8'h2C
`define PMP_OFS_PINST   8'h30
`define PMP_OFS_VRMS    8'h34
`define PMP_OFS_IRMS    8'h38
`define PMP_OFS_PACT    8'h3C
`define PMP_OFS_SAPP    8'h40
`define PMP_OFS_QAVG    8'h44
`define PMP_OFS_PHASE   8'h48
// Field positions
`define PMP_CFG_PGA      0
`define PMP_CFG_KDIV_LO  4
`define PMP_MODE_ROLLOFF 0
`define PMP_MODE_VDC     1
`define PMP_MODE_IDC     2
`define PMP_MODE_PIN2    3
`define PMP_MODE_PIN3_LO 4
`define PMP_ST_SAMPLE    0
`define PMP_ST_CYCLE     1
// Reset values
`define PMP_RST_CONFIG  32'h00000010
`define PMP_RST_MODE    6'h00
`define PMP_RST_GAIN    24'h400000
`define PMP_RST_CYCLES  24'h000FA0
`define PMP_RST_EPSILON 24'h033333
`define PMP_RST_PRATE   24'h010000
`define PMP_RST_PWIDTH  16'h0001
// Timing counts and scaling
`define PMP_WORD_DIV    10
`define PMP_ENERGY_THR  27'sh0800000
`endif

// ==== pmp_pkg.sv ====
package pmp_pkg;
	typedef enum logic [1:0] {CALC_IDLE, CALC_MEAN, CALC_ROOT} pmp_calc_state_type;
endpackage : pmp_pkg

// ==== power_measure_pulse_core_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "pmp_params.svh"
module power_measure_pulse_core_tb_top
	import pmp_pkg::*;
;
	logic        clk_in = 1'b0;
	logic        nrst_in = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h00000000;
	logic [23:0] vsamp = 24'hF00000;
	logic [23:0] isamp = 24'h100000;
	logic        smon = 1'b0;
	wire         hready;
	wire         hresp;
	wire  [31:0] hrdata;
	wire         pga;
	wire         irq_n;
	wire         e1_n;
	wire         e2;
	wire         e3_n;
	wire  [15:0] c1;
	wire  [15:0] cp;
	wire  [15:0] c2;
	logic [15:0] n0;
	logic [15:0] p0;
	logic [31:0] rd;
	int          err_total;
	int          checked;
	logic [7:0]  ra [0:10] = '{`PMP_OFS_CONFIG, `PMP_OFS_MODE, `PMP_OFS_VGAIN,
		`PMP_OFS_IGAIN, `PMP_OFS_CYCLES, `PMP_OFS_EPSILON, `PMP_OFS_PRATE,
		`PMP_OFS_PWIDTH, `PMP_OFS_STATUS, `PMP_OFS_MASK, 8'h4C};
	logic [31:0] rv [0:10] = '{32'h00000010, 32'h0, 32'h00400000, 32'h00400000,
		32'h00000FA0, 32'h00033333, 32'h00010000, 32'h00000001, 32'h0, 32'h0, 32'h0};
	////////////////////////////////////////////////////////////////////////////
	// Design and far side
	pmp_core u_pmp_core (.clk_in(clk_in), .nrst_in(nrst_in), .hsel_in(hsel),
		.haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
		.hwdata_in(hwdata), .hready_in(hready), .hreadyout_out(hready),
		.hresp_out(hresp), .hrdata_out(hrdata), .vsamp_in(vsamp), .isamp_in(isamp),
		.supply_monitor_compare_in(smon), .current_pga_high_out(pga),
		.irq_n_out(irq_n), .active_pulse_out_n(e1_n), .sign_or_apparent_out(e2),
		.third_pulse_out_n(e3_n));
	pmp_far_model u_pmp_far_model (.clk_in(clk_in), .e1_n_in(e1_n), .e2_in(e2),
		.e1_falls_out(c1), .e1_pos_out(cp), .e2_falls_out(c2));
	// Clock and watchdog
	always #5 clk_in = ~clk_in;
	initial begin
		#600000;
		err_total++;
		wrap_up();
	end
	////////////////////////////////////////////////////////////////////////////
	// Compare and count
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// One single word transfer; read data lands in rd
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'b10;
		hwrite <= w;
		hsize <= 3'b010;
		@(posedge clk_in);
		while (hready !== 1'b1) @(posedge clk_in);
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge clk_in);
		while (hready !== 1'b1) @(posedge clk_in);
		rd = hrdata;
	endtask : bus
	// Read status until the given flag shows
	task automatic poll(input int b);
		int n;
		n = 0;
		rd = 32'h0;
		while (rd[b] !== 1'b1 && n < 1500) begin
			bus(1'b0, `PMP_OFS_STATUS, 32'h0);
			n++;
		end
	endtask : poll
	task automatic wrap_up;
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrap_up
	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		err_total = 0;
		checked = 0;
		repeat (20) @(posedge clk_in);
		nrst_in <= 1'b1;
		chk("irq idle", {31'h0, irq_n}, 32'h1);
		chk("pins idle", {29'h0, e1_n, e2, e3_n}, 32'h7);
		chk("pga reset", {31'h0, pga}, 32'h0);
		for (int i = 0; i < 11; i++) begin
			bus(1'b0, ra[i], 32'h0);
			chk("reset reg", rd, rv[i]);
		end
		bus(1'b1, `PMP_OFS_CONFIG, 32'h00000011);
		repeat (2) @(posedge clk_in);
		chk("pga high", {31'h0, pga}, 32'h1);
		bus(1'b1, `PMP_OFS_CONFIG, 32'h00000010);
		bus(1'b1, `PMP_OFS_MODE, 32'h00000010);
		smon <= 1'b1;
		repeat (5) @(posedge clk_in);
		chk("monitor high", {31'h0, e3_n}, 32'h1);
		smon <= 1'b0;
		repeat (5) @(posedge clk_in);
		chk("monitor low", {31'h0, e3_n}, 32'h0);
		// Sample flag, interrupt and voltage sign
		bus(1'b1, `PMP_OFS_MODE, 32'h00000020);
		bus(1'b1, `PMP_OFS_MASK, 32'h00000001);
		bus(1'b1, `PMP_OFS_STATUS, 32'h00000003);
		poll(0);
		chk("sample flag", rd & 32'h1, 32'h1);
		repeat (3) @(posedge clk_in);
		chk("irq set", {31'h0, irq_n}, 32'h0);
		chk("volt sign", {31'h0, e3_n}, 32'h0);
		bus(1'b0, `PMP_OFS_VINST, 32'h0);
		chk("vinst", rd, 32'hFFF00000);
		bus(1'b1, `PMP_OFS_STATUS, 32'h00000001);
		repeat (3) @(posedge clk_in);
		chk("irq clear", {31'h0, irq_n}, 32'h1);
		bus(1'b0, `PMP_OFS_STATUS, 32'h0);
		chk("flag cleared", rd & 32'h1, 32'h0);
		bus(1'b1, `PMP_OFS_VGAIN, 32'h00200000);
		poll(0);
		bus(1'b0, `PMP_OFS_VINST, 32'h0);
		chk("vinst half", rd, 32'hFFF80000);
		// Cycle count of one
		bus(1'b1, `PMP_OFS_CYCLES, 32'h00000001);
		bus(1'b1, `PMP_OFS_MASK, 32'h00000002);
		bus(1'b1, `PMP_OFS_STATUS, 32'h00000003);
		poll(1);
		chk("cycle flag", rd & 32'h2, 32'h2);
		repeat (3) @(posedge clk_in);
		chk("irq cycle", {31'h0, irq_n}, 32'h0);
		// Energy pulses with positive power
		vsamp <= 24'h700000;
		isamp <= 24'h700000;
		bus(1'b1, `PMP_OFS_VGAIN, 32'h00400000);
		bus(1'b1, `PMP_OFS_PRATE, 32'h00FFFFFF);
		bus(1'b1, `PMP_OFS_MODE, 32'h00000000);
		n0 = c1;
		p0 = cp;
		repeat (8192) @(posedge clk_in);
		chk("e1 pulses", {31'h0, c1 != n0}, 32'h1);
		chk("e1 positive", {16'h0, c1 - n0}, {16'h0, cp - p0});
		// Results of one-sample cycles with both inputs at 0.875
		bus(1'b0, `PMP_OFS_VRMS, 32'h0);
		chk("vrms", rd, 32'h00700000);
		bus(1'b0, `PMP_OFS_PACT, 32'h0);
		chk("pact", rd, 32'h00620000);
		bus(1'b0, `PMP_OFS_SAPP, 32'h0);
		chk("sapp", rd, 32'h00620000);
		bus(1'b0, `PMP_OFS_QAVG, 32'h0);
		chk("qavg held", rd, 32'h0);
		bus(1'b1, `PMP_OFS_MODE, 32'h00000008);
		n0 = c2;
		repeat (8192) @(posedge clk_in);
		chk("e2 apparent", {31'h0, c2 != n0}, 32'h1);
		// Apparent pulses on pin3 track those on pin2
		bus(1'b1, `PMP_OFS_MODE, 32'h00000038);
		repeat (2) @(posedge clk_in);
		n0 = 16'h0000;
		p0 = 16'h0000;
		repeat (4096) begin
			@(posedge clk_in);
			if (e3_n === 1'b0)
				n0 = n0 + 16'h0001;
			if (e3_n !== e2)
				p0 = p0 + 16'h0001;
		end
		chk("e3 apparent", {31'h0, n0 != 16'h0000}, 32'h1);
		chk("e3 like e2", {16'h0, p0}, 32'h0);
		// Pulse low time of two sample periods
		bus(1'b1, `PMP_OFS_PWIDTH, 32'h00000002);
		@(negedge e1_n);
		@(negedge e1_n);
		n0 = 16'h0000;
		while (e1_n === 1'b0) begin
			@(posedge clk_in);
			n0 = n0 + 16'h0001;
		end
		chk("pulse width", {31'h0, n0 >= 16'h0600 && n0 <= 16'h0A00}, 32'h1);
		// Reset in mid-run restores pins, interrupt and mode
		nrst_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		nrst_in <= 1'b1;
		chk("pins rst", {29'h0, e1_n, e2, e3_n}, 32'h7);
		chk("irq rst", {31'h0, irq_n}, 32'h1);
		bus(1'b0, `PMP_OFS_MODE, 32'h0);
		chk("mode rst", rd, 32'h0);
		wrap_up();
	end
endmodule : power_measure_pulse_core_tb_top
`default_nettype wire
